// file: rtl/cgct_pkg.sv
/*
  constants, types and register map of the clock generator control and trim registers.
  assumes a simple strobe register port and source clocks sampled as levels on mclk_i.
*/
// What this block does
// R1: bus clock is the selected source divided by 1, 2, 4 or 8; reset 2.
// R2: bit 5 picks the high or low frequency range of the external reference.
// R3: bit 4 picks high-gain or low-power operation of the oscillator.
// R4: bit 3 powers the loop down while a bypassed mode is active.
// R5: bit 2 takes the reference from the crystal, else from the external clock input.
// R6: bit 1 gates the external reference clock output; inactive while clear.
// R7: in stop the reference keeps running only if bit 0 and output or external mode.
// R8: eight-bit binary-weighted trim sets the internal reference period; larger is longer.
// R9: one extra fine-trim bit lives in the status and control register.
// R10: software copies any stored factory trim into the trim register itself.
// R11: two-bit source select: loop, internal, external; reserved code acts as loop.
// R12: changing trim while locked in internal loop modes clears lock until reacquired.
// R13: divider changes apply only at a period boundary, so no short bus clock pulse.
package cgct_pkg;

  // ===========================================================
  // register map
  localparam logic [7:0] CGCT_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] CGCT_OFS_CTRL_TWO = 8'h01;
  localparam logic [7:0] CGCT_OFS_TRIM = 8'h02;
  localparam logic [7:0] CGCT_OFS_STATUS = 8'h03;

  // ===========================================================
  // reset values
  localparam logic [7:0] CGCT_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] CGCT_RST_CTRL_TWO = 8'h40;
  localparam logic [7:0] CGCT_RST_TRIM = 8'h80;
  localparam logic CGCT_RST_FINE = 1'b0;

  // ===========================================================
  // field positions
  localparam int CGCT_SRC_HI = 7;
  localparam int CGCT_SRC_LO = 6;
  localparam int CGCT_DIV_HI = 7;
  localparam int CGCT_DIV_LO = 6;
  localparam int CGCT_RANGE_BIT = 5;
  localparam int CGCT_GAIN_BIT = 4;
  localparam int CGCT_LP_BIT = 3;
  localparam int CGCT_XTAL_BIT = 2;
  localparam int CGCT_OUT_EN_BIT = 1;
  localparam int CGCT_KEEP_BIT = 0;
  localparam int CGCT_LOCK_BIT = 6;
  localparam int CGCT_FINE_BIT = 0;

  // ===========================================================
  // encodings
  localparam logic [1:0] CGCT_SRC_LOOP = 2'h0;
  localparam logic [1:0] CGCT_SRC_INT = 2'h1;
  localparam logic [1:0] CGCT_SRC_EXT = 2'h2;
  localparam logic [1:0] CGCT_DIV_BY1 = 2'h0;

  typedef enum logic [3:0] {
    loop_engaged_internal_mode,
    loop_bypassed_internal_mode,
    loop_engaged_external_mode,
    loop_bypassed_external_mode,
    pll_engaged_external_mode,
    pll_bypassed_external_mode,
    low_power_internal_bypass_mode,
    low_power_external_bypass_mode
  } cgct_mode_type;

  typedef struct packed {
    logic range_high;
    logic high_gain;
    logic use_crystal;
    logic enable;
  } cgct_osc_cfg_type;

endpackage

// file: rtl/cgct_top.sv
/*
  clock generator second control, trim and related status/control registers, with bus divider,
  external reference gating, stop retention and lock clearing on trim change.
  assumes all clock inputs are slow enough to be sampled as levels by mclk_i.
*/
`timescale 1ns/1ps
module cgct_top
  import cgct_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic loop_clk_i,
  input wire logic int_ref_clk_i,
  input wire logic osc_clk_i,
  input wire logic ext_clk_i,
  input wire cgct_mode_type clk_mode_i,
  input wire logic stop_i,
  input wire logic loop_locked_i,
  output logic bus_clk_o,
  output logic ext_ref_output_clock_o,
  output logic ext_ref_running_o,
  output cgct_osc_cfg_type osc_cfg_o,
  output logic loop_power_down_o,
  output logic [8:0] int_ref_trim_o,
  output logic lock_status_o
);

  // ===========================================================
  // helpers
  function automatic logic [2:0] half_count(input logic [1:0] div);
    case (div)
      2'h1: half_count = 3'h1;
      2'h2: half_count = 3'h2;
      2'h3: half_count = 3'h4;
      default: half_count = 3'h1;
    endcase
  endfunction

  function automatic logic is_bypassed(input cgct_mode_type m);
    case (m)
      loop_bypassed_internal_mode,
      loop_bypassed_external_mode,
      pll_bypassed_external_mode,
      low_power_internal_bypass_mode,
      low_power_external_bypass_mode: is_bypassed = 1'b1;
      default: is_bypassed = 1'b0;
    endcase
  endfunction

  function automatic logic uses_ext_ref(input cgct_mode_type m);
    case (m)
      loop_engaged_external_mode,
      loop_bypassed_external_mode,
      pll_engaged_external_mode,
      pll_bypassed_external_mode,
      low_power_external_bypass_mode: uses_ext_ref = 1'b1;
      default: uses_ext_ref = 1'b0;
    endcase
  endfunction

  // ===========================================================
  // registers
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic [7:0] trim_r;
  logic fine_r;
  logic [7:0] rdata_r;
  logic wr_one;
  logic wr_two;
  logic wr_trim;
  logic wr_stat;

  assign wr_one = reg_write_i && (reg_addr_i == ADDR_W'(CGCT_OFS_CTRL_ONE));
  assign wr_two = reg_write_i && (reg_addr_i == ADDR_W'(CGCT_OFS_CTRL_TWO));
  assign wr_trim = reg_write_i && (reg_addr_i == ADDR_W'(CGCT_OFS_TRIM));
  assign wr_stat = reg_write_i && (reg_addr_i == ADDR_W'(CGCT_OFS_STATUS));

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_one_r <= CGCT_RST_CTRL_ONE;
      ctrl_two_r <= CGCT_RST_CTRL_TWO;
    end else begin
      if (wr_one) begin
        ctrl_one_r <= reg_wdata_i;
      end
      if (wr_two) begin
        ctrl_two_r <= reg_wdata_i;
      end
    end
  end

  // factory trim is not loaded here; boot software must copy it in
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trim_r <= CGCT_RST_TRIM;
      fine_r <= CGCT_RST_FINE;
    end else begin
      if (wr_trim) begin
        trim_r <= reg_wdata_i; // R8 R10
      end
      if (wr_stat) begin
        fine_r <= reg_wdata_i[CGCT_FINE_BIT]; // R9
      end
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        ADDR_W'(CGCT_OFS_CTRL_ONE): rdata_r <= ctrl_one_r;
        ADDR_W'(CGCT_OFS_CTRL_TWO): rdata_r <= ctrl_two_r;
        ADDR_W'(CGCT_OFS_TRIM): rdata_r <= trim_r;
        ADDR_W'(CGCT_OFS_STATUS): rdata_r <= {1'b0, lock_status_o, 5'h00, fine_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ===========================================================
  // source select and bus divider
  logic [1:0] src_sel;
  logic ext_ref_src;
  logic src_clk;
  logic src_d_r;
  logic src_rise;
  logic [1:0] active_div_r;
  logic [2:0] cnt_r;
  logic bus_clk_r;
  logic at_boundary;
  logic half_done;

  assign src_sel = ctrl_one_r[CGCT_SRC_HI:CGCT_SRC_LO];
  assign ext_ref_src = ctrl_two_r[CGCT_XTAL_BIT] ? osc_clk_i : ext_clk_i; // R5

  always_comb begin
    case (src_sel) // R11
      CGCT_SRC_INT: src_clk = int_ref_clk_i;
      CGCT_SRC_EXT: src_clk = ext_ref_src;
      default: src_clk = loop_clk_i;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src_clk;
    end
  end
  assign src_rise = src_clk && !src_d_r;

  // a period starts where the output rises; the new ratio is taken only there, so
  // a change never cuts a high or low phase short
  assign half_done = (3'(cnt_r + 3'h1) == half_count(active_div_r));
  assign at_boundary = (active_div_r == CGCT_DIV_BY1) || (!bus_clk_r && half_done);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_div_r <= CGCT_RST_CTRL_TWO[CGCT_DIV_HI:CGCT_DIV_LO];
      cnt_r <= 3'h0;
      bus_clk_r <= 1'b0;
    end else if (src_rise) begin
      if (at_boundary) begin
        active_div_r <= ctrl_two_r[CGCT_DIV_HI:CGCT_DIV_LO]; // R13
        cnt_r <= 3'h0;
        bus_clk_r <= 1'b1; // R1
      end else if (half_done) begin
        cnt_r <= 3'h0;
        bus_clk_r <= !bus_clk_r; // R1
      end else begin
        cnt_r <= 3'(cnt_r + 3'h1);
      end
    end else if (active_div_r == CGCT_DIV_BY1) begin
      bus_clk_r <= src_clk; // R1
    end
  end
  assign bus_clk_o = bus_clk_r;

  // ===========================================================
  // external reference, stop retention, oscillator settings
  logic stop_d_r;
  logic keep_r;
  logic keep_cond;
  logic running;
  logic ext_out_r;
  logic ext_run_r;
  cgct_osc_cfg_type osc_cfg_r;
  logic lp_r;

  assign keep_cond = ctrl_two_r[CGCT_KEEP_BIT]
                     && (ctrl_two_r[CGCT_OUT_EN_BIT] || uses_ext_ref(clk_mode_i));

  // the retention decision is frozen at stop entry; the mode input means little once stopped
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_d_r <= 1'b0;
      keep_r <= 1'b0;
    end else begin
      stop_d_r <= stop_i;
      if (stop_i && !stop_d_r) begin
        keep_r <= keep_cond; // R7
      end
    end
  end

  assign running = (stop_i && !stop_d_r) ? keep_cond :
                   stop_i ? keep_r :
                   (ctrl_two_r[CGCT_OUT_EN_BIT] || uses_ext_ref(clk_mode_i)); // R7

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_run_r <= 1'b0;
      ext_out_r <= 1'b0;
    end else begin
      ext_run_r <= running;
      ext_out_r <= ctrl_two_r[CGCT_OUT_EN_BIT] && running && ext_ref_src; // R6
    end
  end
  assign ext_ref_running_o = ext_run_r;
  assign ext_ref_output_clock_o = ext_out_r;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_cfg_r <= '0;
      lp_r <= 1'b0;
    end else begin
      osc_cfg_r.range_high <= ctrl_two_r[CGCT_RANGE_BIT]; // R2
      osc_cfg_r.high_gain <= ctrl_two_r[CGCT_GAIN_BIT]; // R3
      osc_cfg_r.use_crystal <= ctrl_two_r[CGCT_XTAL_BIT]; // R5
      osc_cfg_r.enable <= running && ctrl_two_r[CGCT_XTAL_BIT];
      lp_r <= ctrl_two_r[CGCT_LP_BIT] && is_bypassed(clk_mode_i); // R4
    end
  end
  assign osc_cfg_o = osc_cfg_r;
  assign loop_power_down_o = lp_r;

  // ===========================================================
  // trim output and lock status
  logic [8:0] trim_out_r;
  logic lock_r;
  logic blocked_r;
  logic trim_kill;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trim_out_r <= {CGCT_RST_TRIM, CGCT_RST_FINE};
    end else begin
      trim_out_r <= {trim_r, fine_r}; // R8 R9
    end
  end
  assign int_ref_trim_o = trim_out_r;

  assign trim_kill = wr_trim && (reg_wdata_i != trim_r) && lock_r
                     && ((clk_mode_i == loop_engaged_internal_mode)
                         || (clk_mode_i == loop_bypassed_internal_mode));

  // lock stays clear until the loop drops and regains lock, since that is the only
  // reacquire evidence the loop gives us
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blocked_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      if (trim_kill) begin
        blocked_r <= 1'b1; // R12
        lock_r <= 1'b0; // R12
      end else begin
        if (!loop_locked_i) begin
          blocked_r <= 1'b0;
        end
        lock_r <= loop_locked_i && !blocked_r;
      end
    end
  end
  assign lock_status_o = lock_r;

  // ===========================================================
  // checks
  property p_div_apply;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (src_rise && at_boundary) |=> (active_div_r == $past(ctrl_two_r[CGCT_DIV_HI:CGCT_DIV_LO])) && bus_clk_r;
  endproperty
  a_div_apply: assert property (p_div_apply) else $error("divider not applied at boundary"); // R1

  property p_div_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (!src_rise && active_div_r != CGCT_DIV_BY1) |=> $stable(bus_clk_r) && $stable(active_div_r);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("bus clock moved between source edges"); // R13

  property p_range;
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_two ##1 1 |=> osc_cfg_o.range_high == $past(reg_wdata_i[CGCT_RANGE_BIT], 2);
  endproperty
  a_range: assert property (p_range) else $error("range select not followed"); // R2

  property p_gain;
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_two ##1 1 |=> osc_cfg_o.high_gain == $past(reg_wdata_i[CGCT_GAIN_BIT], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain select not followed"); // R3

  property p_lp;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_two_r[CGCT_LP_BIT] && clk_mode_i == loop_bypassed_external_mode) |=> loop_power_down_o;
  endproperty
  a_lp: assert property (p_lp) else $error("loop not powered down in bypass"); // R4

  property p_engaged_on;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_mode_i == loop_engaged_internal_mode) |=> !loop_power_down_o;
  endproperty
  a_engaged_on: assert property (p_engaged_on) else $error("loop powered down while engaged"); // R4

  property p_out_gate;
    @(posedge mclk_i) disable iff (!arst_n_i)
    !ctrl_two_r[CGCT_OUT_EN_BIT] |=> !ext_ref_output_clock_o;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("reference output active while disabled"); // R6

  property p_out_follow;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_two_r[CGCT_OUT_EN_BIT] && !stop_i) |=> ext_ref_output_clock_o == $past(ext_ref_src);
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("reference output not following source"); // R5

  property p_stop_off;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (stop_i && !stop_d_r && !ctrl_two_r[CGCT_KEEP_BIT]) ##1 stop_i |=> !ext_ref_running_o;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("reference kept in stop without retention"); // R7

  property p_trim_out;
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_trim |=> ##1 int_ref_trim_o[8:1] == $past(reg_wdata_i, 2);
  endproperty
  a_trim_out: assert property (p_trim_out) else $error("trim not reaching output"); // R8

  property p_fine_out;
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_stat |=> ##1 int_ref_trim_o[0] == $past(reg_wdata_i[CGCT_FINE_BIT], 2);
  endproperty
  a_fine_out: assert property (p_fine_out) else $error("fine trim not reaching output"); // R9

  property p_lock_clear;
    @(posedge mclk_i) disable iff (!arst_n_i)
    trim_kill |=> !lock_status_o ##1 !lock_status_o;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared by trim change"); // R12

endmodule

// file: verif/cgct_ext_ref_model.sv
/*
  external reference model: a crystal oscillator and an external clock source.
  assumes the crystal runs whenever the block sets use_crystal, whatever the enable field says.
*/
`timescale 1ns/1ps
module cgct_ext_ref_model
  import cgct_pkg::*;
#(
  parameter int OSC_HALF = 5,
  parameter int EXT_HALF = 3
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire cgct_osc_cfg_type cfg_i,
  output logic osc_clk_o,
  output logic ext_clk_o
);
  int osc_cnt;
  int ext_cnt;

  // ===========================================================
  // crystal: stops low when use_crystal is clear, so a stale level never looks alive
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_cnt <= 0;
      osc_clk_o <= 1'b0;
    end else if (!cfg_i.use_crystal) begin
      osc_cnt <= 0;
      osc_clk_o <= 1'b0;
    end else begin
      osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == OSC_HALF - 1) osc_clk_o <= ~osc_clk_o;
    end
  end

  // ===========================================================
  // external clock source runs free
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_cnt <= 0;
      ext_clk_o <= 1'b0;
    end else begin
      ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
      if (ext_cnt == EXT_HALF - 1) ext_clk_o <= ~ext_clk_o;
    end
  end
endmodule

// file: verif/cgct_top_tb_top.sv
/*
  self-checking bench of the control-two, trim and status/control registers.
  assumes cgct_top and the external reference model; loop and internal clocks are made here.
*/
`timescale 1ns/1ps
module cgct_top_tb_top
  import cgct_pkg::*;
;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } cgct_row_type;
  localparam int CEIL = 30000;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic loop_clk_i = 1'b0;
  logic int_ref_clk_i = 1'b0;
  logic osc_clk_i;
  logic ext_clk_i;
  cgct_mode_type clk_mode_i = loop_engaged_internal_mode;
  logic stop_i = 1'b0;
  logic loop_locked_i = 1'b0;
  logic bus_clk_o;
  logic ext_ref_output_clock_o;
  logic ext_ref_running_o;
  cgct_osc_cfg_type osc_cfg_o;
  logic loop_power_down_o;
  logic [8:0] int_ref_trim_o;
  logic lock_status_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int lcnt = 0;
  int icnt = 0;
  int bper = 0;
  int blast = 0;
  int erise = 0;
  logic bprev = 1'b0;
  logic eprev = 1'b0;
  // ===========================================================
  // table of plain register cases: address, write data, read-back
  cgct_row_type rows [8] = '{'{8'h01, 8'h34, 8'h34}, '{8'h01, 8'hCB, 8'hCB}, '{8'h02, 8'h00, 8'h00},
    '{8'h02, 8'hFF, 8'hFF}, '{8'h03, 8'hFF, 8'h01}, '{8'h03, 8'h00, 8'h00}, '{8'h10, 8'h5A, 8'h00},
    '{8'h00, 8'hC0, 8'hC0}};
  int hv [4] = '{2, 3, 5, 2};
  logic [7:0] eo [3] = '{8'h00, 8'h06, 8'h02};
  int er [3] = '{0, 12, 20};
  logic [7:0] sc2 [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
  cgct_mode_type smd [4] = '{loop_engaged_internal_mode, loop_engaged_internal_mode,
    low_power_external_bypass_mode, loop_engaged_internal_mode};
  logic sexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  cgct_top DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .loop_clk_i(loop_clk_i),
    .int_ref_clk_i(int_ref_clk_i), .osc_clk_i(osc_clk_i), .ext_clk_i(ext_clk_i), .clk_mode_i(clk_mode_i),
    .stop_i(stop_i), .loop_locked_i(loop_locked_i), .bus_clk_o(bus_clk_o),
    .ext_ref_output_clock_o(ext_ref_output_clock_o), .ext_ref_running_o(ext_ref_running_o),
    .osc_cfg_o(osc_cfg_o), .loop_power_down_o(loop_power_down_o), .int_ref_trim_o(int_ref_trim_o),
    .lock_status_o(lock_status_o));
  cgct_ext_ref_model #(.OSC_HALF(5), .EXT_HALF(3)) ref_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .cfg_i(osc_cfg_o), .osc_clk_o(osc_clk_i), .ext_clk_o(ext_clk_i));

  always #10 mclk_i = ~mclk_i;

  // ===========================================================
  // source clocks and edge monitors; periods counted in mclk_i cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    lcnt <= (lcnt == 1) ? 0 : lcnt + 1;
    if (lcnt == 1) loop_clk_i <= ~loop_clk_i;
    icnt <= (icnt == 2) ? 0 : icnt + 1;
    if (icnt == 2) int_ref_clk_i <= ~int_ref_clk_i;
    bprev <= bus_clk_o;
    if (bus_clk_o && !bprev) begin
      bper <= cyc - blast;
      blast <= cyc;
    end
    eprev <= ext_ref_output_clock_o;
    if (ext_ref_output_clock_o && !eprev) erise <= erise + 1;
    if (cyc == CEIL) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge mclk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge mclk_i);
    reg_read_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] c2;
    logic [7:0] te;
    logic fe;
    int e0;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    // reset values; the trim register is never loaded from storage by itself
    rd(8'h01, d);
    chk("ctrl_two_rst", 16'h40, 16'(d));
    rd(8'h02, d);
    chk("trim_rst", 16'h80, 16'(d));
    chk("trim_out_rst", 16'h100, 16'(int_ref_trim_o));
    $display("test reset values done");
    c2 = 8'h40;
    te = 8'h80;
    fe = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk("readback", 16'(rows[i].rexp), 16'(d));
      if (rows[i].addr == 8'h01) c2 = rows[i].wdata;
      if (rows[i].addr == 8'h02) te = rows[i].wdata;
      if (rows[i].addr == 8'h03) fe = rows[i].wdata[0];
      tick(2);
      chk("osc_cfg", 16'({c2[5], c2[4], c2[2], c2[1] & c2[2]}), 16'(osc_cfg_o));
      chk("trim_out", 16'({te, fe}), 16'(int_ref_trim_o));
    end
    $display("test table done");
    // every source code against every divider; the crystal drives the external source
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 4; v++) begin
        wr(8'h00, {s[1:0], 6'h00});
        wr(8'h01, {v[1:0], 6'h04});
        tick(250);
        chk("bus_period", 16'(2 * hv[s] * (1 << v)), 16'(bper));
      end
    end
    $display("test divider done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h01, eo[k]);
      tick(20);
      e0 = erise;
      tick(120);
      chk("ext_out_rises", 16'h1, 16'(erise - e0 >= er[k] - 1 && erise - e0 <= er[k] + 1));
      chk("osc_enable", 16'(eo[k][1] & eo[k][2]), 16'(osc_cfg_o.enable));
    end
    $display("test ext output done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h01, sc2[k]);
      clk_mode_i <= smd[k];
      tick(3);
      @(posedge mclk_i);
      stop_i <= 1'b1;
      tick(4);
      chk("ext_running_stop", 16'(sexp[k]), 16'(ext_ref_running_o));
      @(posedge mclk_i);
      stop_i <= 1'b0;
    end
    $display("test stop done");
    // bypassed modes are 1, 3, 5, 6 and 7 in the mode order
    for (int p = 0; p < 2; p++) begin
      wr(8'h01, {4'h0, p[0], 3'h0});
      for (int m = 0; m < 8; m++) begin
        @(posedge mclk_i);
        clk_mode_i <= cgct_mode_type'(4'(m));
        tick(3);
        chk("loop_pd", 16'(p[0] & (8'hEA >> m)), 16'(loop_power_down_o));
      end
    end
    $display("test low power done");
    @(posedge mclk_i);
    clk_mode_i <= loop_engaged_internal_mode;
    loop_locked_i <= 1'b1;
    tick(3);
    chk("lock_set", 16'h1, 16'(lock_status_o));
    rd(8'h03, d);
    chk("lock_read", 16'h40, 16'(d & 8'h40));
    wr(8'h02, 8'hFF);
    tick(2);
    chk("lock_same_trim", 16'h1, 16'(lock_status_o));
    wr(8'h02, 8'h81);
    tick(5);
    chk("lock_cleared", 16'h0, 16'(lock_status_o));
    @(posedge mclk_i);
    loop_locked_i <= 1'b0;
    tick(2);
    @(posedge mclk_i);
    loop_locked_i <= 1'b1;
    tick(3);
    chk("lock_back", 16'h1, 16'(lock_status_o));
    @(posedge mclk_i);
    clk_mode_i <= loop_engaged_external_mode;
    wr(8'h02, 8'h82);
    tick(3);
    chk("lock_ext_mode", 16'h1, 16'(lock_status_o));
    $display("test lock done");
    // second reset in mid-run brings the registers back
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    tick(2);
    chk("trim_out_rerst", 16'h100, 16'(int_ref_trim_o));
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rd(8'h01, d);
    chk("ctrl_two_rerst", 16'h40, 16'(d));
    $display("test reset done");
    end_of_test();
  end
endmodule
